// ---- design/scsmf_top.sv ----
// Serial peripheral port: pin ownership, control, status flags, mode fault and a byte shifter.
// How it works
// - Serial enable hands port D bits 5..2 to the serial logic.
// - Enabled peripheral treats select pin as active-low select regardless of direction.
// - Controller with select direction 0 watches pin; low means mode fault.
// - Controller with select direction 1: pin is plain output, no fault detection.
// - Clock pin input as peripheral; driven as controller only when direction is 1.
// - Controller-out pin input as peripheral; drives as controller only with direction 1.
// - Controller-in pin input as controller; drives as peripheral only with direction 1.
// - Interrupt requested while done or fault set, enabled and processor mask clear.
// - Serial enable bit turns the whole interface off or on.
// - Open-drain select makes all six port D pins drive low only.
// - Role bit 0 gives peripheral role, 1 gives controller role.
// - Clock idle level bit sets idle low or idle high.
// - Clock phase bit selects between two transfer formats.
// - Controller clock is E clock divided by 2, 4, 16 or 32.
// - Done flag sets at transfer end; clears by status read then data access.
// - Collision flag sets on data write mid-transfer; same clearing sequence.
// - Status register read-only; bit 5 and bits 3..0 read zero.
// - Fault flag sets on select low; clears by status read then control write.
// - Fault clears four serial direction bits, role and enable, and sets flag.
// - Controller transfer starts on data write, runs until done flag sets.
// - Colliding data write is discarded; running transfer continues.
`timescale 1ns/1ps
`include "scsmf_map.svh"

module scsmf_top (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Register bus
	input  wire scsmf_pkg::scsmf_axi_req_s axi_req,
	output      scsmf_pkg::scsmf_axi_rsp_s axi_rsp,
	// Processor interrupt mask bit
	input  wire logic                  cpu_irq_mask,
	// Port D pins, bits 5..0
	input  wire logic [5:0]            port_i,
	output      scsmf_pkg::scsmf_pins_s port_pins,
	// Interrupt request
	output      logic                  irq_req
);
	import scsmf_pkg::*;

	typedef struct packed {
		scsmf_axi_rsp_s rsp;
		logic           aw_got;
		logic [7:0]     aw_addr;
		logic           w_got;
		logic [7:0]     w_data;
		logic [7:0]     dir;
		logic [7:0]     ctrl;
		logic [7:0]     port_out;
		logic           done;
		logic           write_collision_flag;
		logic           mode_fault_flag;
		logic           arm_done;
		logic           arm_write_collision_flag;
		logic           arm_mode_fault_flag;
		scsmf_state_e   st;
		logic [7:0]     shift;
		logic [7:0]     rx_buf;
		logic [3:0]     bits;
		logic           half;
		logic [7:0]     ediv;
		logic [4:0]     rdiv;
		logic           sck;
		logic           sck_in_q;
		logic           sel_in_q;
		logic           data_out;
		scsmf_pins_s    pins;
		logic           irq;
	} scsmf_state_s;

	scsmf_state_s s_q, s_d;

	// Half-period of the serial clock in E-clock ticks, from the rate code.
	function automatic logic [4:0] half_ticks(input logic [1:0] code);
		case (code)
			2'b00:   half_ticks = 5'h01;
			2'b01:   half_ticks = 5'h02;
			2'b10:   half_ticks = 5'h08;
			default: half_ticks = 5'h10;
		endcase
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] a, input scsmf_state_s s);
		if (a == `SCSMF_OFF_DIR) begin
			reg_read = s.dir;
		end else if (a == `SCSMF_OFF_CTRL) begin
			reg_read = s.ctrl;
		end else if (a == `SCSMF_OFF_STAT) begin
			reg_read = {s.done, s.write_collision_flag, 1'b0, s.mode_fault_flag, 4'h0};
		end else if (a == `SCSMF_OFF_DATA) begin
			reg_read = s.rx_buf;
		end else if (a == `SCSMF_OFF_PORT) begin
			reg_read = {2'b00, s.port_out[5:0]};
		end else begin
			reg_read = 8'h00;
		end
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `SCSMF_OFF_DIR) || (a == `SCSMF_OFF_CTRL) || (a == `SCSMF_OFF_STAT)
			|| (a == `SCSMF_OFF_DATA) || (a == `SCSMF_OFF_PORT);
	endfunction

	logic       en;
	logic       ctl;
	logic       sel_n;
	logic       fault;
	logic       wr_fire;
	logic       rd_fire;
	logic [7:0] rd_addr;
	logic       data_acc;
	logic       e_tick;
	logic       r_tick;
	logic       set_done;
	logic       sck_edge;
	logic       lead_edge;
	logic       sample_now;
	logic       busy;
	logic [5:0] drv;
	logic [5:0] ena;

	always_comb begin
		s_d = s_q;
		en  = s_q.ctrl[`SCSMF_CTRL_EN];
		ctl = s_q.ctrl[`SCSMF_CTRL_ROLE];
		sel_n = port_i[5];
		// Fault only when the select pin is an input of a controller.
		fault = en && ctl && !s_q.dir[`SCSMF_DIR_SEL] && !sel_n;
		set_done = 1'b0;
		e_tick = 1'b0;
		r_tick = 1'b0;
		sck_edge = 1'b0;
		lead_edge = 1'b0;
		sample_now = 1'b0;
		// In peripheral role busy spans the select-low period, so a data write then collides.
		busy = (s_q.st != SCSMF_IDLE);

		// Register bus: write address and data taken in either order.
		// Each ready is a one-cycle pulse, so a valid that is still held is never taken twice.
		s_d.rsp.awready = 1'b0;
		s_d.rsp.wready  = 1'b0;
		s_d.rsp.arready = 1'b0;
		if (!s_q.aw_got && axi_req.awvalid && !s_q.rsp.bvalid) begin
			s_d.rsp.awready = !s_q.rsp.awready;
			if (s_q.rsp.awready) begin
				s_d.aw_got = 1'b1;
				s_d.aw_addr = axi_req.awaddr;
			end
		end
		if (!s_q.w_got && axi_req.wvalid && !s_q.rsp.bvalid) begin
			s_d.rsp.wready = !s_q.rsp.wready;
			if (s_q.rsp.wready) begin
				s_d.w_got = axi_req.wstrb[0];
				s_d.w_data = axi_req.wdata[7:0];
				s_d.w_got = 1'b1;
			end
		end
		// The response waits until both halves of the write are in.
		wr_fire = s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid;
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp = is_mapped(s_q.aw_addr) ? 2'b00 : 2'b10;
		end
		if (s_q.rsp.bvalid && axi_req.bready) begin
			s_d.rsp.bvalid = 1'b0;
		end
		// Read data come from the registers as they stand at the address handshake.
		rd_fire = s_q.rsp.arready && axi_req.arvalid;
		rd_addr = axi_req.araddr;
		if (axi_req.arvalid && !s_q.rsp.rvalid && !s_q.rsp.arready) begin
			s_d.rsp.arready = 1'b1;
		end
		if (rd_fire) begin
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata = {24'h000000, reg_read(rd_addr, s_q)};
			s_d.rsp.rresp = is_mapped(rd_addr) ? 2'b00 : 2'b10;
		end else if (s_q.rsp.rvalid && axi_req.rready) begin
			s_d.rsp.rvalid = 1'b0;
		end

		// Any data access, read or write, completes the clearing sequence of the armed done and collision flags.
		data_acc = (rd_fire && rd_addr == `SCSMF_OFF_DATA) || (wr_fire && s_q.aw_addr == `SCSMF_OFF_DATA);
		if (data_acc) begin
			if (s_q.arm_done) begin
				s_d.done = 1'b0;
			end
			if (s_q.arm_write_collision_flag) begin
				s_d.write_collision_flag = 1'b0;
			end
			s_d.arm_done = 1'b0;
			s_d.arm_write_collision_flag = 1'b0;
		end
		// A status read arms only the flags that it saw set; one that rises later stays up.
		if (rd_fire && rd_addr == `SCSMF_OFF_STAT) begin
			s_d.arm_done = s_q.done;
			s_d.arm_write_collision_flag = s_q.write_collision_flag;
			s_d.arm_mode_fault_flag = s_q.mode_fault_flag;
		end

		if (wr_fire && s_q.aw_addr == `SCSMF_OFF_DIR) begin
			s_d.dir = s_q.w_data;
		end
		if (wr_fire && s_q.aw_addr == `SCSMF_OFF_PORT) begin
			s_d.port_out = s_q.w_data;
		end
		if (wr_fire && s_q.aw_addr == `SCSMF_OFF_CTRL) begin
			s_d.ctrl = s_q.w_data;
			if (s_q.arm_mode_fault_flag) begin
				s_d.mode_fault_flag = 1'b0;
				s_d.arm_mode_fault_flag = 1'b0;
			end
		end

		// Serial clock: E clock ticks divided per the rate code.
		// The divider runs free, so the first edge of a transfer may come up to a half period late.
		if (s_q.ediv == `SCSMF_ECLK_DIV - 8'h01) begin
			s_d.ediv = 8'h00;
			e_tick = 1'b1;
		end else begin
			s_d.ediv = s_q.ediv + 8'h01;
		end
		// Greater-or-equal ends a half period at once when a lower rate code is written mid-count.
		if (e_tick) begin
			if (s_q.rdiv >= half_ticks(s_q.ctrl[1:0]) - 5'h01) begin
				s_d.rdiv = 5'h00;
				r_tick = 1'b1;
			end else begin
				s_d.rdiv = s_q.rdiv + 5'h01;
			end
		end

		// Previous pin levels, for edge detection in the peripheral role.
		s_d.sck_in_q = port_i[4];
		s_d.sel_in_q = sel_n;

		// Data write: load shifter when idle, otherwise flag a collision and discard.
		if (wr_fire && s_q.aw_addr == `SCSMF_OFF_DATA && en) begin
			if (busy) begin
				s_d.write_collision_flag = 1'b1;
			end else begin
				s_d.shift = s_q.w_data;
				if (ctl) begin
					s_d.st = SCSMF_XFER;
					s_d.bits = 4'h0;
					s_d.half = 1'b0;
				end
			end
		end

		case (s_q.st)
			SCSMF_IDLE: begin
				s_d.sck = s_q.ctrl[`SCSMF_CTRL_CLOCK_IDLE_LEVEL];
				// Phase 0 needs the first bit out before the first edge, so take it from a byte loaded now.
				s_d.data_out = s_d.shift[7];
				if (en && !ctl && !sel_n && (!s_q.sel_in_q || !s_q.ctrl[`SCSMF_CTRL_CLOCK_PHASE_SELECT])) begin
					s_d.st = SCSMF_SLV;
					s_d.bits = 4'h0;
				end
			end
			SCSMF_XFER: begin
				if (r_tick) begin
					s_d.half = !s_q.half;
					// Phase 0 samples on the first edge, phase 1 shifts on it.
					sample_now = (s_q.half == s_q.ctrl[`SCSMF_CTRL_CLOCK_PHASE_SELECT]);
					s_d.sck = s_q.ctrl[`SCSMF_CTRL_CLOCK_IDLE_LEVEL] ^ !s_q.half;
					if (sample_now) begin
						s_d.shift = {s_q.shift[6:0], port_i[2]};
						s_d.bits = s_q.bits + 4'h1;
					end else if (s_q.bits != 4'h0 || s_q.ctrl[`SCSMF_CTRL_CLOCK_PHASE_SELECT]) begin
						s_d.data_out = s_q.shift[7];
					end
					// Phase 0 ends on its eighth trailing edge; phase 1 idles the clock for half a period
					// after its eighth sample, so neither format gives a ninth edge or sample.
					if (!sample_now && s_q.bits == `SCSMF_BITS) begin
						s_d.sck = s_q.ctrl[`SCSMF_CTRL_CLOCK_IDLE_LEVEL];
						set_done = 1'b1;
					end
				end
			end
			default: begin
				sck_edge = (port_i[4] != s_q.sck_in_q);
				lead_edge = sck_edge && (port_i[4] != s_q.ctrl[`SCSMF_CTRL_CLOCK_IDLE_LEVEL]);
				sample_now = sck_edge && (lead_edge != s_q.ctrl[`SCSMF_CTRL_CLOCK_PHASE_SELECT]);
				// Select high aborts a byte, and the bit count starts afresh for the next one.
				if (sel_n || !en || ctl) begin
					s_d.st = SCSMF_IDLE;
				end else if (sample_now) begin
					s_d.shift = {s_q.shift[6:0], port_i[3]};
					s_d.bits = s_q.bits + 4'h1;
					if (s_q.bits == `SCSMF_BITS - 4'h1) begin
						set_done = 1'b1;
						// Phase 0 stays busy until select rises.
						if (s_q.ctrl[`SCSMF_CTRL_CLOCK_PHASE_SELECT]) begin
							s_d.st = SCSMF_IDLE;
						end
					end
				end else if (sck_edge) begin
					s_d.data_out = s_q.shift[7];
				end
			end
		endcase
		if (set_done) begin
			s_d.done = 1'b1;
			s_d.rx_buf = s_d.shift;
			if (s_q.st == SCSMF_XFER) begin
				s_d.st = SCSMF_IDLE;
			end
		end

		// Mode fault wins over any register write in the same cycle.
		// Direction bits and enable drop at one edge so that no serial driver is left on.
		if (fault) begin
			s_d.dir = s_d.dir & ~`SCSMF_DIR_SERIAL;
			s_d.ctrl[`SCSMF_CTRL_ROLE] = 1'b0;
			s_d.ctrl[`SCSMF_CTRL_EN] = 1'b0;
			s_d.mode_fault_flag = 1'b1;
			s_d.st = SCSMF_IDLE;
		end
		if (!s_d.ctrl[`SCSMF_CTRL_EN]) begin
			s_d.st = SCSMF_IDLE;
		end

		// Pins: general purpose unless the serial logic owns them.
		drv = s_d.port_out[5:0];
		ena = s_d.dir[5:0];
		if (s_d.ctrl[`SCSMF_CTRL_EN]) begin
			if (s_d.ctrl[`SCSMF_CTRL_ROLE]) begin
				drv[4] = s_d.sck;
				drv[3] = s_d.data_out;
				ena[2] = 1'b0;
				ena[5] = s_d.dir[`SCSMF_DIR_SEL];
			end else begin
				drv[2] = s_d.data_out;
				ena[2] = s_d.dir[`SCSMF_DIR_CIN] && !sel_n;
				ena[3] = 1'b0;
				ena[4] = 1'b0;
				ena[5] = 1'b0;
			end
		end
		// Open drain: drive only lows.
		// A one is left to the external pull-up, so that pin is simply not driven.
		if (s_d.ctrl[`SCSMF_CTRL_OD]) begin
			ena = ena & ~drv;
			drv = 6'h00;
		end
		s_d.pins.o = drv;
		s_d.pins.oe = ena;

		// A level request: it stands while the done or fault flag is up and falls when that flag is cleared or masked.
		s_d.irq = s_d.ctrl[`SCSMF_CTRL_IRQEN] && (s_d.done || s_d.mode_fault_flag) && !cpu_irq_mask;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Only the direction, control and port registers and the transfer state take reset values of their own.
			s_q <= '0;
			s_q.dir <= `SCSMF_RST_DIR;
			s_q.ctrl <= `SCSMF_RST_CTRL;
			s_q.port_out <= `SCSMF_RST_PORT;
			s_q.st <= SCSMF_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign axi_rsp = s_q.rsp;
	assign port_pins = s_q.pins;
	assign irq_req = s_q.irq;

endmodule // scsmf_top

// ---- include/scsmf_map.svh ----
// Register offsets, field positions, reset values and timing counts of the serial port block.
`ifndef SCSMF_MAP_SVH
`define SCSMF_MAP_SVH

`define SCSMF_OFF_DIR      8'h00
`define SCSMF_OFF_CTRL     8'h04
`define SCSMF_OFF_STAT     8'h08
`define SCSMF_OFF_DATA     8'h0C
`define SCSMF_OFF_PORT     8'h10

`define SCSMF_DIR_SEL      5
`define SCSMF_DIR_CLK      4
`define SCSMF_DIR_COUT     3
`define SCSMF_DIR_CIN      2
`define SCSMF_DIR_SERIAL   8'h3C

`define SCSMF_CTRL_IRQEN   7
`define SCSMF_CTRL_EN      6
`define SCSMF_CTRL_OD      5
`define SCSMF_CTRL_ROLE    4
`define SCSMF_CTRL_CLOCK_IDLE_LEVEL    3
`define SCSMF_CTRL_CLOCK_PHASE_SELECT    2
`define SCSMF_CTRL_RATE_HI 1
`define SCSMF_CTRL_RATE_LO 0

`define SCSMF_STAT_DONE    7
`define SCSMF_STAT_WRITE_COLLISION_FLAG    6
`define SCSMF_STAT_MODE_FAULT_FLAG    4

`define SCSMF_RST_DIR      8'h00
`define SCSMF_RST_CTRL     8'h04
`define SCSMF_RST_PORT     8'h00

`define SCSMF_ECLK_DIV     8'h04
`define SCSMF_BITS         4'h8

`endif

// ---- include/scsmf_pkg.sv ----
// Types shared by the serial port control, status and mode-fault block.
package scsmf_pkg;

	typedef struct packed {
		logic [5:0] o;
		logic [5:0] oe;
	} scsmf_pins_s;

	typedef enum logic [1:0] {
		SCSMF_IDLE  = 2'b00,
		SCSMF_XFER  = 2'b01,
		SCSMF_SLV   = 2'b10
	} scsmf_state_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} scsmf_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} scsmf_axi_rsp_s;

endpackage

// ---- tb/scsmf_checker.sv ----
// Concurrent checks on the serial port block, seen from its top ports only.
`timescale 1ns/1ps
`include "scsmf_map.svh"
module scsmf_checker (
	// Clock and reset
	input wire logic                      aclk,
	input wire logic                      aresetn,
	// Register bus
	input wire scsmf_pkg::scsmf_axi_req_s axi_req,
	input wire scsmf_pkg::scsmf_axi_rsp_s axi_rsp,
	// Pins and interrupt
	input wire logic                      cpu_irq_mask,
	input wire logic [5:0]                port_i,
	input wire scsmf_pkg::scsmf_pins_s    port_pins,
	input wire logic                      irq_req
);
	import scsmf_pkg::*;
	logic [7:0] ctl_q;
	logic [7:0] dir_q;
	logic [2:0] age_q;
	logic       wr;
	logic       st;
	// Shadows lead the design, so checks wait until a setting has settled.
	assign wr = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	assign st = age_q == 3'h7;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= `SCSMF_RST_CTRL;
			dir_q <= `SCSMF_RST_DIR;
			age_q <= 3'h0;
		end else if (wr) begin
			age_q <= 3'h0;
			if (axi_req.awaddr == `SCSMF_OFF_CTRL)
				ctl_q <= axi_req.wdata[7:0];
			if (axi_req.awaddr == `SCSMF_OFF_DIR)
				dir_q <= axi_req.wdata[7:0];
		end else if (!st) begin
			age_q <= age_q + 3'h1;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_released;
		##[1:4] port_pins.oe[5:2] == 4'h0;
	endsequence
	a_od_low_only: assert property (st && ctl_q[5] |-> (port_pins.oe & port_pins.o) == 6'h00)
		else $error("open-drain pin driven high");
	a_periph_inputs: assert property (st && ctl_q[6] && !ctl_q[4] |-> port_pins.oe[4:3] == 2'h0)
		else $error("peripheral drives clock or data-in pin");
	a_ctrl_in_input: assert property (st && ctl_q[6] && ctl_q[4] |-> !port_pins.oe[2])
		else $error("controller drives its data input pin");
	a_fault_release: assert property (st && ctl_q[6] && ctl_q[4] && !dir_q[5] && !port_i[5] |-> s_released)
		else $error("pins not released after mode fault");
	a_irq_masked: assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !irq_req)
		else $error("interrupt raised while masked");
	a_stat_zero: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr == `SCSMF_OFF_STAT
		|=> (axi_rsp.rdata & 32'hFFFFFF2F) == 32'h0)
		else $error("unused status bits read non-zero");
	a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read answer dropped");
	a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready |-> ##[1:3] axi_rsp.bvalid)
		else $error("write answer late");
endmodule // scsmf_checker

// ---- tb/scsmf_partner.sv ----
// Far-side serial peripheral driving the select pin and pin 2, with pull-ups on port pins 4, 3, 1 and 0.
`timescale 1ns/1ps
module scsmf_partner (
	// Pins of the block
	input wire scsmf_pkg::scsmf_pins_s pins,
	input wire logic                   sel_low,
	// Bench reset, low while the block's pins are still unknown
	input wire logic                   resetn,
	output     logic [5:0]             port_i,
	// Byte received from the block
	output     logic [7:0]             rx
);
	import scsmf_pkg::*;
	logic [7:0] tx = 8'hA5;
	logic       miso = 1'b0;
	logic [3:0] cnt = 4'h0;
	logic [5:0] ext;
	initial rx = 8'h00;
	always_comb begin
		ext = 6'h3F;
		ext[5] = !sel_low;
		ext[2] = miso;
	end
	// Pull-ups win unless someone pulls low.
	assign port_i = ext & ~(pins.oe & ~pins.o);
	// Pin edges during reset come from unknown levels and are no clock.
	always @(posedge port_i[4]) begin
		if (resetn) begin
			miso <= tx[3'h7 - cnt[2:0]];
			cnt <= cnt + 4'h1;
		end
	end
	always @(negedge port_i[4]) begin
		if (resetn) begin
			rx <= {rx[6:0], port_i[3]};
			// Past its byte the data line must not keep the last bit.
			if (cnt == 4'h8) begin
				miso <= ~miso;
				cnt <= 4'h0;
			end
		end
	end
endmodule // scsmf_partner

// ---- tb/scsmf_top_tb.sv ----
// Register-level testbench of the serial port control, status and mode-fault block.
`timescale 1ns/1ps
`include "scsmf_map.svh"
module scsmf_top_tb;
	import scsmf_pkg::*;
	logic           aclk = 1'b0;
	logic           aresetn = 1'b0;
	logic           mask = 1'b1;
	logic           sel_low = 1'b0;
	logic [5:0]     port_i;
	logic [7:0]     rx;
	scsmf_axi_req_s req = '0;
	scsmf_axi_rsp_s rsp;
	scsmf_pins_s    pins;
	logic           irq;
	logic [7:0]     d;
	logic [1:0]     r;
	int             bad_count = 0;
	int             check_count = 0;
	int             dv[4] = '{1, 2, 8, 16};
	realtime        t0;

	always #2 aclk = ~aclk;

	scsmf_top dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .cpu_irq_mask(mask),
		.port_i(port_i), .port_pins(pins), .irq_req(irq));
	scsmf_partner far_u (.pins(pins), .sel_low(sel_low), .resetn(aresetn), .port_i(port_i), .rx(rx));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h000000, v};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata[7:0];
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	task automatic wait_done();
		do rd(`SCSMF_OFF_STAT);
		while (!d[7]);
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#200000;
		bad_count++;
		print_verdict();
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		wr(`SCSMF_OFF_STAT, 8'hFF);
		rchk(`SCSMF_OFF_STAT, 8'h00);
		rd(8'h14);
		chk(r, 2'b10);
		$display("Test registers done");
		wr(`SCSMF_OFF_DIR, 8'h1C);
		wr(`SCSMF_OFF_CTRL, 8'hD4);
		wr(`SCSMF_OFF_DATA, 8'h3C);
		wr(`SCSMF_OFF_DATA, 8'h99);
		wait_done();
		chk(d, 8'hC0);
		chk(irq, 1'b0);
		mask <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		rchk(`SCSMF_OFF_DATA, 8'hA5);
		chk(rx, 8'h3C);
		rchk(`SCSMF_OFF_STAT, 8'h00);
		chk(irq, 1'b0);
		$display("Test transfer done");
		for (int k = 0; k < 4; k++) begin
			wr(`SCSMF_OFF_CTRL, 8'h54 | 8'(k));
			wr(`SCSMF_OFF_DATA, 8'h00);
			@(posedge port_i[4]);
			t0 = $realtime;
			@(posedge port_i[4]);
			chk(32'($rtoi(($realtime - t0) / 4.0)), 32'(8 * dv[k]));
			wait_done();
			chk(irq, 1'b0);
			rd(`SCSMF_OFF_DATA);
		end
		wr(`SCSMF_OFF_CTRL, 8'h50);
		wr(`SCSMF_OFF_DATA, 8'h7F);
		@(posedge port_i[4]);
		chk(pins.o[3], 1'b0);
		@(negedge port_i[4]);
		chk(pins.o[3], 1'b1);
		wait_done();
		rd(`SCSMF_OFF_DATA);
		wr(`SCSMF_OFF_CTRL, 8'h5C);
		repeat (4) @(posedge aclk);
		chk(pins.o[4], 1'b1);
		$display("Test rates done");
		wr(`SCSMF_OFF_CTRL, 8'hD4);
		sel_low <= 1'b1;
		repeat (8) @(posedge aclk);
		rchk(`SCSMF_OFF_DIR, 8'h00);
		rchk(`SCSMF_OFF_CTRL, 8'h84);
		rchk(`SCSMF_OFF_STAT, 8'h10);
		chk(irq, 1'b1);
		wr(`SCSMF_OFF_CTRL, 8'h04);
		rchk(`SCSMF_OFF_STAT, 8'h00);
		wr(`SCSMF_OFF_DIR, 8'h3C);
		wr(`SCSMF_OFF_CTRL, 8'h54);
		repeat (8) @(posedge aclk);
		rchk(`SCSMF_OFF_STAT, 8'h00);
		chk(pins.oe[5], 1'b1);
		sel_low <= 1'b0;
		$display("Test mode fault done");
		wr(`SCSMF_OFF_CTRL, 8'h44);
		repeat (8) @(posedge aclk);
		chk(pins.oe[4:3], 2'b00);
		wr(`SCSMF_OFF_PORT, 8'h3C);
		wr(`SCSMF_OFF_CTRL, 8'h04);
		repeat (4) @(posedge aclk);
		chk(pins.oe[5:2], 4'hF);
		wr(`SCSMF_OFF_CTRL, 8'h24);
		repeat (4) @(posedge aclk);
		chk(pins.oe & pins.o, 6'h00);
		chk(pins.oe, 6'h00);
		wr(`SCSMF_OFF_PORT, 8'h00);
		repeat (4) @(posedge aclk);
		chk(pins.oe, 6'h3C);
		$display("Test pins done");
		print_verdict();
	end
endmodule // scsmf_top_tb

bind scsmf_top scsmf_checker chk_u (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.cpu_irq_mask(cpu_irq_mask), .port_i(port_i), .port_pins(port_pins), .irq_req(irq_req));
